// ===== pcr_ctrl.sv
// start-up configuration, reset and power-state control of the phy
// assumes pins arrive asynchronously and the register port runs on clk
//
// Functional notes
// R1 - re-evaluate link configuration at power-on, any reset and link failure
// R2 - managed mode: straps only give defaults, then registers rule
// R3 - hardware mode: register writes blocked, straps load at each reset
// R4 - modes: fiber, 100 full/half, 10 full/half, or autonegotiation
// R5 - forced mode applies at once; otherwise autonegotiation is started
// R6 - power-down pin stops port and clock, tristates pads, refuses access
// R7 - control power-down bit shuts the port, registers stay accessible
// R8 - sleep enabled by pin, or by config bit in managed mode
// R9 - sleep after no line energy for the selected timeout
// R10 - register port keeps working while asleep
// R11 - energy wakes the port; no link within timeout means sleep again
// R12 - sleep never active in fiber mode
// R13 - hardware reset latches autoneg and speed setup from straps
// R14 - software reset restores last latched strap values, no resample
// R15 - registers unavailable for 1 ms after hardware reset release
// R16 - registers readable during software reset; bit clears when done
// R17 - software polls the reset bit until it reads zero
// R18 - three led pins give the strap bits, open-drain or open-source
// R19 - strap1 low: autoneg off, speed and duplex from straps 2 and 3
// R20 - strap1 high: autoneg on, advertisement bits derived from straps
// R21 - management clock no faster than 8 MHz; the register port here runs on the 10 MHz clk
// R22 - disable pin high: hardware mode, register access blocked
// R23 - sleep timers count on the clock and restart on line energy
// R24 - straps sampled at reset release and kept for software resets
`timescale 1ns/1ns
module pcr_ctrl #(
    parameter int unsigned MS_CYCLES = pcr_pkg::MS_CYCLES
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               sys_rst,
    // register port
    input  wire logic [4:0]         regAddr,
    input  wire logic [15:0]        regWdata,
    input  wire logic               regWr,
    input  wire logic               regRd,
    output logic      [15:0]        regRdata,
    // pins
    input  wire logic               hwPowerdownPin,
    input  wire logic               mgmtDisablePin,
    input  wire logic               sleepPin,
    input  wire logic               fiberDetectPin,
    input  wire logic [2:0]         ledStrapPin,
    output logic      [2:0]         ledStrapOut,
    output logic      [2:0]         ledStrapOeN,
    // line side
    input  wire logic [2:0]         ledDrive,
    input  wire logic               lineEnergy,
    input  wire logic               linkUp,
    // port control
    output logic                    portEnable,
    output logic                    clockEnable,
    output logic                    padTristate,
    output logic                    pullEnable,
    output logic                    regReady,
    output logic                    cfgApply,
    output logic                    anStart,
    output pcr_pkg::pcr_opmode_t    opMode,
    output logic                    speed100,
    output logic                    fullDuplex,
    output logic                    anEnable,
    output logic                    fiberMode,
    output logic                    sleepActive
);
    import pcr_pkg::*;

    localparam int unsigned HOLD_CYCLES = HW_HOLD_MS * MS_CYCLES;

    ////////////////////////////////////////////////////////////////////////
    // synchronisers: no reset so the straps are valid at release
    logic [7:0]  pinMeta;
    logic [7:0]  pinSync;
    always_ff @(posedge clk) begin
        pinMeta <= {ledStrapPin, fiberDetectPin, lineEnergy, sleepPin,
                    mgmtDisablePin, hwPowerdownPin};
        pinSync <= pinMeta;
    end
    logic pdnSync;
    logic mdisSync;
    logic sleepSync;
    logic energySync;
    logic fiberSync;
    assign pdnSync    = pinSync[0];
    assign mdisSync   = pinSync[1];
    assign sleepSync  = pinSync[2];
    assign energySync = pinSync[3];
    assign fiberSync  = pinSync[4];

    ////////////////////////////////////////////////////////////////////////
    // strap latch
    logic       strapTaken;
    logic [2:0] strapLatched;
    logic       fiberLatched;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            strapTaken   <= 1'b0;
            strapLatched <= 3'h0;
            fiberLatched <= 1'b0;
        end else if (!strapTaken) begin
            strapTaken   <= 1'b1;             // R24
            strapLatched <= pinSync[7:5];     // R18
            fiberLatched <= fiberSync;
        end
    end

    function automatic logic [15:0] strapCtrl(input logic [2:0] s);
        logic [15:0] c;
        c = CTRL_RESET_VAL;
        c[CTRL_AN]     = s[0];                // R19 R20
        c[CTRL_SPEED]  = s[0] | s[1];
        c[CTRL_DUPLEX] = s[2];
        return c;
    endfunction

    function automatic logic [15:0] strapAdv(input logic [2:0] s,
                                             input logic [15:0] old);
        logic [15:0] a;
        a = old;
        if (s[0]) begin                       // R20
            a[ADV_100FD] = s[2];
            a[ADV_COPPER_100_MODE] = 1'b1;
            a[ADV_10FD]  = s[1] & s[2];
            a[ADV_10T]   = s[1];
        end
        return a;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // post-reset hold; the counter stops once the hold is over
    logic [31:0] holdCnt;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            holdCnt  <= 32'h0;
            regReady <= 1'b0;
        end else if (!regReady) begin
            holdCnt  <= holdCnt + 32'h1;
            regReady <= (holdCnt == HOLD_CYCLES - 1);     // R15
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register port
    logic [15:0] ctrl;
    logic [15:0] adv;
    logic [15:0] cfg;
    logic [7:0]  swRstCnt;
    logic        accessOk;
    logic        wrOk;
    logic        swDone;
    pcr_sleep_t  slpState;

    // hardware mode and power-down both shut the port out
    assign accessOk = regReady & ~mdisSync & ~pdnSync;    // R6 R22
    assign wrOk     = regWr & accessOk;                   // R3
    assign swDone   = ctrl[CTRL_RESET] && (swRstCnt == 8'h1);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl     <= CTRL_RESET_VAL;
            adv      <= ADV_RESET_VAL;
            cfg      <= CFG_RESET_VAL;
            swRstCnt <= 8'h0;
        end else if (!strapTaken) begin
            ctrl <= strapCtrl(pinSync[7:5]);              // R13
            adv  <= strapAdv(pinSync[7:5], ADV_RESET_VAL);
        end else if (wrOk && regAddr == REG_CTRL &&
                     regWdata[CTRL_RESET] &&
                     (!ctrl[CTRL_RESET] || swDone)) begin
            // a new request beats the completion in the same cycle
            ctrl[CTRL_RESET] <= 1'b1;
            swRstCnt         <= 8'(SW_RESET_CYCLES);
        end else if (ctrl[CTRL_RESET]) begin
            swRstCnt <= swRstCnt - 8'h1;
            if (swDone) begin
                ctrl <= strapCtrl(strapLatched);          // R14 R16
                adv  <= strapAdv(strapLatched, adv);
                cfg  <= CFG_RESET_VAL;
            end
        end else if (wrOk) begin                          // R2
            case (regAddr)
                REG_CTRL: ctrl <= regWdata;
                REG_ADV:  adv  <= regWdata;
                REG_CFG:  cfg  <= regWdata;
                default:  ;
            endcase
        end
    end

    // read answer stands for one cycle only; still served while asleep
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            regRdata <= 16'h0;
        end else if (regRd && accessOk) begin             // R10 R16
            case (regAddr)
                REG_CTRL:  regRdata <= ctrl;
                REG_STAT:  regRdata <= STAT_BASE_VAL |
                                       (16'(linkUp) << STAT_LINK);
                REG_ADV:   regRdata <= adv;
                REG_CFG:   regRdata <= cfg;
                REG_STATE: regRdata <= {9'h0, mdisSync, fiberLatched,
                                        opMode, slpState};
                default:   regRdata <= 16'h0;
            endcase
        end else begin
            regRdata <= 16'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration evaluation
    logic portRun;
    logic portRunPrev;
    logic linkPrev;
    logic ctrlChanged;
    logic evalReq;
    assign portRun = strapTaken & ~pdnSync & ~ctrl[CTRL_PDOWN];  // R7
    // a write or reload lands at its edge; evaluate a cycle later on it
    assign evalReq = portRun & (~portRunPrev | ctrlChanged |
                     (linkPrev & ~linkUp));               // R1

    function automatic pcr_opmode_t decodeMode(input logic [15:0] c,
                                               input logic fib);
        if (fib)
            return OPM_FIBER100;
        else if (c[CTRL_AN])
            return OPM_AUTONEG;
        else if (c[CTRL_SPEED])
            return c[CTRL_DUPLEX] ? OPM_TX100_FD : OPM_TX100_HD;
        else
            return c[CTRL_DUPLEX] ? OPM_T10_FD : OPM_T10_HD;
    endfunction

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            portRunPrev <= 1'b0;
            linkPrev    <= 1'b0;
            ctrlChanged <= 1'b0;
            cfgApply    <= 1'b0;
            anStart     <= 1'b0;
            opMode      <= OPM_AUTONEG;
        end else begin
            portRunPrev <= portRun;
            linkPrev    <= linkUp;
            ctrlChanged <= swDone | (wrOk & (regAddr == REG_CTRL));
            cfgApply    <= evalReq;
            anStart     <= evalReq & ctrl[CTRL_AN] & ~fiberLatched; // R5
            if (evalReq)
                opMode <= decodeMode(ctrl, fiberLatched); // R4
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sleep
    logic        sleepEn;
    logic [31:0] slpCyc;
    logic [11:0] slpMs;
    logic [11:0] slpLimit;
    logic        slpTimeout;

    // fiber never sleeps: its signal-detect input is not twisted-pair energy
    assign sleepEn = (mdisSync ? sleepSync : cfg[CFG_SLEEP])   // R8
                     & ~fiberLatched & portRun;                // R12

    always_comb begin
        case (cfg[CFG_TMO_LO +: 2])
            2'h0:    slpLimit = 12'(SLEEP_MS_0);
            2'h1:    slpLimit = 12'(SLEEP_MS_1);
            2'h2:    slpLimit = 12'(SLEEP_MS_2);
            default: slpLimit = 12'(SLEEP_MS_3);
        endcase
    end
    assign slpTimeout = (slpMs == slpLimit);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            slpState <= SLP_AWAKE;
            slpCyc   <= 32'h0;
            slpMs    <= 12'h0;
        end else if (!sleepEn) begin
            slpState <= SLP_AWAKE;
            slpCyc   <= 32'h0;
            slpMs    <= 12'h0;
        end else begin
            if (slpCyc == MS_CYCLES - 1) begin
                slpCyc <= 32'h0;
                slpMs  <= slpMs + 12'h1;
            end else begin
                slpCyc <= slpCyc + 32'h1;
            end
            case (slpState)
                SLP_AWAKE: begin
                    if (energySync) begin
                        slpCyc <= 32'h0;                  // R23
                        slpMs  <= 12'h0;
                    end else if (slpTimeout) begin
                        slpState <= SLP_ASLEEP;           // R9
                    end
                end
                SLP_ASLEEP: begin
                    slpCyc <= 32'h0;
                    slpMs  <= 12'h0;
                    if (energySync)
                        slpState <= SLP_CHECK;            // R11
                end
                SLP_CHECK: begin
                    if (linkUp) begin
                        slpState <= SLP_AWAKE;
                        slpCyc   <= 32'h0;
                        slpMs    <= 12'h0;
                    end else if (slpTimeout) begin
                        slpState <= SLP_ASLEEP;           // R11
                    end
                end
                default: slpState <= SLP_AWAKE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port and pad outputs
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            portEnable  <= 1'b0;
            clockEnable <= 1'b0;
            padTristate <= 1'b1;
            pullEnable  <= 1'b0;
            speed100    <= 1'b0;
            fullDuplex  <= 1'b0;
            anEnable    <= 1'b0;
            fiberMode   <= 1'b0;
            sleepActive <= 1'b0;
            ledStrapOut <= 3'h0;
            ledStrapOeN <= 3'h7;
        end else begin
            portEnable  <= portRun && slpState != SLP_ASLEEP;  // R7
            clockEnable <= ~pdnSync;                           // R6
            padTristate <= pdnSync;
            pullEnable  <= ~pdnSync;
            speed100    <= ctrl[CTRL_SPEED] | fiberLatched;
            fullDuplex  <= ctrl[CTRL_DUPLEX];
            anEnable    <= ctrl[CTRL_AN];
            fiberMode   <= fiberLatched;
            sleepActive <= (slpState == SLP_ASLEEP);
            // drive toward the level opposite the strap wiring
            ledStrapOut <= ~strapLatched;                      // R18
            ledStrapOeN <= ~(ledDrive & {3{strapTaken & ~pdnSync}});
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_read_refused: assert property (   // R22
        regRd && (mdisSync || pdnSync) |=> regRdata == 16'h0)
        else $error("read answered while access is blocked");
    a_adv_locked: assert property (   // R3
        regWr && mdisSync && regAddr == REG_ADV && !ctrl[CTRL_RESET]
        |=> $stable(adv))
        else $error("advertisement written in hardware mode");
    a_hold_len: assert property (   // R15
        $rose(regReady) |-> $past(holdCnt) == HOLD_CYCLES - 1)
        else $error("register hold not one ms");
    a_swrst_done: assert property (   // R16
        $rose(ctrl[CTRL_RESET]) |-> ctrl[CTRL_RESET][*8]
        ##[1:20] !ctrl[CTRL_RESET])
        else $error("software reset bit timing wrong");
    a_swrst_reload: assert property (   // R14
        swDone && !(wrOk && regWdata[CTRL_RESET])
        |=> ctrl[CTRL_AN] == strapLatched[0]
            && ctrl[CTRL_DUPLEX] == strapLatched[2])
        else $error("software reset did not restore strap values");
    a_strap_latch: assert property (   // R13
        $rose(strapTaken) |-> ctrl[CTRL_AN] == strapLatched[0]
        && ctrl[CTRL_SPEED] == (strapLatched[0] | strapLatched[1]))
        else $error("strap values not loaded at reset release");
    a_soft_pdown: assert property (   // R7
        ctrl[CTRL_PDOWN] |=> !portEnable)
        else $error("port running in software power-down");
    a_hw_pdown: assert property (   // R6
        pdnSync |=> padTristate && !pullEnable && !clockEnable)
        else $error("pads active in hardware power-down");
    a_an_start: assert property (   // R5
        evalReq && ctrl[CTRL_AN] && !fiberLatched |=> cfgApply && anStart)
        else $error("autonegotiation not started");
    a_fiber_awake: assert property (   // R12
        fiberMode |-> slpState == SLP_AWAKE)
        else $error("sleep active in fiber mode");
    a_wake_check: assert property (   // R11
        sleepEn && slpState == SLP_ASLEEP && energySync
        |=> slpState == SLP_CHECK)
        else $error("no wake on line energy");

    c_swrst_done: cover property (swDone);
    c_sleep_in: cover property (slpState == SLP_AWAKE
                                ##1 slpState == SLP_ASLEEP);
    c_wake_ok: cover property (slpState == SLP_CHECK
                               ##1 slpState == SLP_AWAKE);
endmodule

// ===== pcr_far_side.sv
// far-side model: board strap wiring on the led pins and the line
// assumes the bench chooses strap levels and line activity
`timescale 1ns/1ns
module pcr_far_side (
    // strap wiring
    input  wire logic [2:0] strapLevel,
    input  wire logic [2:0] ledStrapOut,
    input  wire logic [2:0] ledStrapOeN,
    output logic      [2:0] ledStrapPin,
    // line
    input  wire logic       energyReq,
    input  wire logic       linkReq,
    output logic            lineEnergy,
    output logic            linkUp
);
    // the strap resistor sets the level only while the driver is off
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            ledStrapPin[i] = ledStrapOeN[i] ? strapLevel[i]
                                            : ledStrapOut[i];
        end
    end
    // no link can be seen without energy on the pair
    assign lineEnergy = energyReq;
    assign linkUp     = linkReq & energyReq;
endmodule

// ===== pcr_pkg.sv
// constants and types for the phy configuration, power and reset block
// assumes a single 10 MHz system clock and a 16-bit register port
package pcr_pkg;
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned HW_HOLD_MS      = 1;
    localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;
    localparam int unsigned SW_RESET_CYCLES = 16;

    // sleep timeout choices in ms, indexed by the 2-bit timeout field
    localparam int unsigned SLEEP_MS_0 = 3040;
    localparam int unsigned SLEEP_MS_1 = 1040;
    localparam int unsigned SLEEP_MS_2 = 2000;
    localparam int unsigned SLEEP_MS_3 = 2560;

    // register numbers
    localparam logic [4:0] REG_CTRL  = 5'h00;
    localparam logic [4:0] REG_STAT  = 5'h01;
    localparam logic [4:0] REG_ADV   = 5'h04;
    localparam logic [4:0] REG_CFG   = 5'h10;
    localparam logic [4:0] REG_STATE = 5'h11;

    // field positions
    localparam int CTRL_RESET  = 15;
    localparam int CTRL_SPEED  = 13;
    localparam int CTRL_AN     = 12;
    localparam int CTRL_PDOWN  = 11;
    localparam int CTRL_DUPLEX = 8;
    localparam int ADV_100FD   = 8;
    localparam int ADV_COPPER_100_MODE   = 7;
    localparam int ADV_10FD    = 6;
    localparam int ADV_10T     = 5;
    localparam int CFG_SLEEP   = 6;
    localparam int CFG_TMO_LO  = 3;
    localparam int STAT_LINK   = 2;

    // reset values
    localparam logic [15:0] CTRL_RESET_VAL = 16'h0000;
    localparam logic [15:0] ADV_RESET_VAL  = 16'h01E1;
    localparam logic [15:0] CFG_RESET_VAL  = 16'h0000;
    localparam logic [15:0] STAT_BASE_VAL  = 16'h0000;

    typedef enum logic [2:0] {
        OPM_FIBER100, OPM_TX100_FD, OPM_TX100_HD,
        OPM_T10_FD, OPM_T10_HD, OPM_AUTONEG
    } pcr_opmode_t;

    typedef enum logic [1:0] {SLP_AWAKE, SLP_ASLEEP, SLP_CHECK} pcr_sleep_t;
endpackage

// ===== tb.sv
// self-checking bench for the configuration, power and reset block
// assumes pcr_pkg, pcr_ctrl and pcr_far_side are compiled first
`timescale 1ns/1ns
module tb;
    import pcr_pkg::*;
    localparam int MSC = 10;
    localparam int TMO = SLEEP_MS_1 * MSC;
    logic        clk = 0, sysRst = 1, regWr = 0, regRd = 0, rdSeen = 0;
    logic [4:0]  regAddr = 0;
    logic [15:0] regWdata = 0, regRdata, lastRd, curMsk;
    logic        pdPin = 0, mdPin = 0, fibPin = 0, engReq = 0, lnkReq = 0;
    logic        slPin = 0;
    logic [2:0]  strapLevel = 0, ledDrive = 0, pin, sOut, sOeN;
    logic        lineEnergy, linkUp, portEnable, clockEnable, padTristate;
    logic        pullEnable, regReady, cfgApply, anStart, speed100;
    logic        fullDuplex, anEnable, fiberMode, sleepActive;
    pcr_opmode_t opMode;
    logic [15:0] expQ[$], mskQ[$];
    int          miscompares = 0, cmpCount = 0, cycles = 0;
    int          apCnt = 0, anCnt = 0, n, k;

    always #50 clk = ~clk;

    pcr_ctrl #(.MS_CYCLES(MSC)) u_pcr_ctrl (
        .clk(clk), .sys_rst(sysRst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .hwPowerdownPin(pdPin),
        .mgmtDisablePin(mdPin), .sleepPin(slPin), .fiberDetectPin(fibPin),
        .ledStrapPin(pin), .ledStrapOut(sOut), .ledStrapOeN(sOeN),
        .ledDrive(ledDrive), .lineEnergy(lineEnergy), .linkUp(linkUp),
        .portEnable(portEnable), .clockEnable(clockEnable),
        .padTristate(padTristate), .pullEnable(pullEnable),
        .regReady(regReady), .cfgApply(cfgApply), .anStart(anStart),
        .opMode(opMode), .speed100(speed100), .fullDuplex(fullDuplex),
        .anEnable(anEnable), .fiberMode(fiberMode),
        .sleepActive(sleepActive));

    pcr_far_side u_pcr_far_side (
        .strapLevel(strapLevel), .ledStrapOut(sOut), .ledStrapOeN(sOeN),
        .ledStrapPin(pin), .energyReq(engReq), .linkReq(lnkReq),
        .lineEnergy(lineEnergy), .linkUp(linkUp));

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finalReport();
        $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
        if (miscompares == 0 && cmpCount > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask

    // a zero mask marks a read whose value is only looked at by the caller
    task automatic rd(input logic [4:0] a, input logic [15:0] e,
                      input logic [15:0] m);
        expQ.push_back(e);
        mskQ.push_back(m);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic hwReset();
        n = 0;
        sysRst <= 1'b1;
        repeat (3) @(posedge clk);
        sysRst <= 1'b0;
        @(posedge clk);
        check(regReady, 1'b0);
        while (regReady !== 1'b1 && n < 2 * MSC) begin
            @(posedge clk);
            n++;
        end
        check({n >= MSC - 2, regReady}, 2'b11);
        @(posedge clk);
    endtask

    task automatic waitSleep();
        n = 0;
        while (sleepActive !== 1'b1 && n < TMO + 100) begin
            @(posedge clk);
            n++;
        end
        check({n >= TMO - 10, sleepActive, portEnable}, 3'b110);
    endtask

    function automatic logic [15:0] ctrlOf(input logic [2:0] s);
        ctrlOf = 16'h0000;
        ctrlOf[CTRL_AN] = s[0];
        ctrlOf[CTRL_SPEED] = s[0] | s[1];
        ctrlOf[CTRL_DUPLEX] = s[2];
    endfunction

    function automatic logic [15:0] advOf(input logic [2:0] s);
        advOf = ADV_RESET_VAL;
        if (s[0]) begin
            advOf[ADV_100FD] = s[2];
            advOf[ADV_10FD] = s[1] & s[2];
            advOf[ADV_10T] = s[1];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // read checker: the oldest note meets the data one cycle after a read
    always @(posedge clk) rdSeen <= regRd;
    always @(negedge clk) begin
        if (rdSeen) begin
            lastRd = regRdata;
            curMsk = mskQ.pop_front();
            check(regRdata & curMsk, expQ.pop_front() & curMsk);
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cfgApply === 1'b1) apCnt++;
        if (anStart === 1'b1) anCnt++;
        if (cycles == 60000) begin
            miscompares++;
            finalReport();
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(11572));
        for (int s = 0; s < 8; s++) begin
            strapLevel <= s[2:0];
            ledDrive <= 3'($urandom);
            hwReset();
            rd(REG_CTRL, ctrlOf(s[2:0]), 16'hFFFF);
            rd(REG_ADV, advOf(s[2:0]), 16'hFFFF);
            @(posedge clk);
            check(portEnable, 1'b1);
            check(pin, s[2:0] ^ ledDrive);
        end
        $display("test straps done");
        strapLevel <= 3'b000;
        wr(REG_CTRL, 16'h0000);
        wr(REG_CFG, 16'h0048);
        wr(REG_CTRL, 16'h8000);
        rd(REG_CTRL, 16'h8000, 16'h8000);
        n = 0;
        do begin
            rd(REG_CTRL, 16'h0000, 16'h0000);
            @(posedge clk);
            n++;
        end while (lastRd[15] !== 1'b0 && n < 40);
        check({n < 12, lastRd[15]}, 2'b10);
        rd(REG_CTRL, ctrlOf(3'b111), 16'hFFFF);
        rd(REG_CFG, CFG_RESET_VAL, 16'hFFFF);
        $display("test software reset done");
        for (int m = 0; m < 5; m++) begin
            k = anCnt;
            wr(REG_CTRL, {2'b00, m[2] | ~m[1], m[2], 3'b000, ~m[0], 8'h00});
            repeat (4) @(posedge clk);
            check({13'h0000, opMode}, 16'(m + 1));
            n = int'({m[2] | ~m[1], ~m[0], m[2]});
            check({speed100, fullDuplex, anEnable}, 16'(n));
            check(16'(anCnt - k), 16'(m == 4));
        end
        engReq <= 1'b1;
        lnkReq <= 1'b1;
        repeat (4) @(posedge clk);
        rd(REG_STAT, 16'(1 << STAT_LINK), 16'hFFFF);
        k = apCnt;
        lnkReq <= 1'b0;
        repeat (6) @(posedge clk);
        check(16'(apCnt - k), 16'h0001);
        $display("test modes done");
        wr(REG_CTRL, 16'h0800);
        repeat (4) @(posedge clk);
        check(portEnable, 1'b0);
        rd(REG_CTRL, 16'h0800, 16'hFFFF);
        wr(REG_CTRL, 16'h0000);
        mdPin <= 1'b1;
        repeat (4) @(posedge clk);
        wr(REG_CFG, 16'h0018);
        rd(REG_CFG, 16'h0000, 16'hFFFF);
        mdPin <= 1'b0;
        repeat (4) @(posedge clk);
        rd(REG_CFG, CFG_RESET_VAL, 16'hFFFF);
        pdPin <= 1'b1;
        repeat (4) @(posedge clk);
        check({portEnable, clockEnable, pullEnable, padTristate}, 4'h1);
        rd(REG_ADV, 16'h0000, 16'hFFFF);
        pdPin <= 1'b0;
        repeat (6) @(posedge clk);
        check(padTristate, 1'b0);
        $display("test power-down done");
        wr(REG_CFG, 16'h0048);
        repeat (20) begin
            engReq <= 1'($urandom);
            @(posedge clk);
        end
        engReq <= 1'b0;
        waitSleep();
        rd(REG_STATE, 16'h0001, 16'h0003);
        engReq <= 1'b1;
        repeat (3) @(posedge clk);
        engReq <= 1'b0;
        repeat (4) @(posedge clk);
        check(sleepActive, 1'b0);
        waitSleep();
        engReq <= 1'b1;
        lnkReq <= 1'b1;
        repeat (10) @(posedge clk);
        check(sleepActive, 1'b0);
        rd(REG_STATE, 16'h0000, 16'h0003);
        wr(REG_CFG, 16'h0008);
        mdPin <= 1'b1;
        slPin <= 1'b1;
        engReq <= 1'b0;
        waitSleep();
        mdPin <= 1'b0;
        slPin <= 1'b0;
        $display("test sleep done");
        fibPin <= 1'b1;
        engReq <= 1'b0;
        hwReset();
        check({13'h0000, opMode}, 16'(OPM_FIBER100));
        check({fiberMode, speed100}, 2'b11);
        wr(REG_CFG, 16'h0048);
        repeat (TMO + 50) @(posedge clk);
        check(sleepActive, 1'b0);
        $display("test fiber done");
        finalReport();
    end
endmodule
